// ==== hdl/alcu_cfg.svh ====
// Constants for the accumulator logic and compare unit
`ifndef ALCU_CFG_SVH
`define ALCU_CFG_SVH

// ==========================================================================
// Widths and fields
`define ALCU_HALF_W     16
`define ALCU_FULL_W     32
`define ALCU_SIGN_BIT   31
`define ALCU_ACC_RESET  32'h0000_0000
// Operation opcodes on the command port
`define ALCU_OP_W       3

`endif

// ==== hdl/alcu_pkg.sv ====
// Types for the accumulator logic and compare unit
`include "alcu_cfg.svh"

package alcu_pkg;

    // ======================================================================
    // Operations
    typedef enum logic [`ALCU_OP_W-1:0] {
        OP_SINGLE_OR,
        OP_DOUBLE_OR,
        OP_SINGLE_XOR,
        OP_DOUBLE_XOR,
        OP_SINGLE_CMP,
        OP_DOUBLE_CMP,
        OP_LOAD
    } op_e;

    // Request from the sequencer
    typedef struct packed {
        op_e                     op;
        logic [`ALCU_FULL_W-1:0] operand;
    } cmd_s;

    // Status flags
    typedef struct packed {
        logic zero_result_flag;
        logic negative_flag;
        logic less_than_flag;
        logic equal_flag;
        logic greater_than_flag;
    } flags_s;

endpackage

// ==== hdl/alcu_compare.sv ====
// Unsigned magnitude comparator at single or double width
`timescale 1ns/1ps
`include "alcu_cfg.svh"

module alcu_compare
    import alcu_pkg::*;
#(
    parameter int FULL_W = `ALCU_FULL_W,
    parameter int HALF_W = `ALCU_HALF_W
) (
    input  wire logic [FULL_W-1:0] acc_i,
    input  wire logic [FULL_W-1:0] operand_i,
    input  wire logic              double_i,
    output logic                   lt_o,
    output logic                   eq_o,
    output logic                   gt_o
);

    logic [FULL_W-1:0] a;
    logic [FULL_W-1:0] b;

    // ======================================================================
    // Single width looks only at the low halves, zero extended
    always_comb begin
        a = double_i ? acc_i : {{(FULL_W-HALF_W){1'b0}}, acc_i[HALF_W-1:0]};
        b = double_i ? operand_i : {{(FULL_W-HALF_W){1'b0}}, operand_i[HALF_W-1:0]};
        lt_o = (a < b);
        eq_o = (a == b);
        gt_o = (a > b);
    end

endmodule

// ==== hdl/accum_logic_compare_unit.sv ====
// Accumulator logic and compare execution unit
`timescale 1ns/1ps
`include "alcu_cfg.svh"

module accum_logic_compare_unit
    import alcu_pkg::*;
#(
    parameter int FULL_W = `ALCU_FULL_W,
    parameter int HALF_W = `ALCU_HALF_W
) (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              cmd_valid_i,
    input  wire cmd_s              cmd_i,
    output logic                   cmd_ready_o,
    output logic                   done_o,
    output logic [FULL_W-1:0]      acc_o,
    output flags_s                 flags_o
);

    // ======================================================================
    // Behaviour summary
    // One request is taken on every edge that sees cmd_valid_i high; the
    // unit never stalls, so ready is tied high and nothing is queued.
    // Result, flags and the done strobe are registered on the taking edge
    // itself, so back-to-back requests chain on the previous result.
    // Single forms read operand bits 15:0 only; double forms expect the
    // sequencer to pack its word pair high word first, in bits 31:16.
    // Compares are unsigned at the operation width; a signed compare
    // would need the sequencer to bias both operands first.
    // Opcode 7 has no meaning: it is ignored but still pulses done_o, so
    // a sequencer fault can never hang the instruction stream.
    // Logic and compare families own separate flags and never clear
    // each other's, which keeps a compare result alive across logic ops.

    // ======================================================================
    // State
    logic [FULL_W-1:0] acc_q;
    logic [FULL_W-1:0] acc_d;
    flags_s            flags_q;
    flags_s            flags_d;
    logic              done_q;
    logic              done_d;
    logic              cmp_lt;
    logic              cmp_eq;
    logic              cmp_gt;
    logic              take;

    // ======================================================================
    // Decode and arithmetic helpers
    // Kept as functions so the comparator and flag paths cannot disagree
    // about which opcodes are double width

    // Logic family: writes the accumulator and the zero/negative flags
    function automatic logic is_logic_op(input op_e op);
        return op inside {OP_SINGLE_OR, OP_DOUBLE_OR, OP_SINGLE_XOR, OP_DOUBLE_XOR};
    endfunction

    // Double forms work on the whole accumulator and a full-width operand
    function automatic logic is_double_op(input op_e op);
        return op inside {OP_DOUBLE_OR, OP_DOUBLE_XOR, OP_DOUBLE_CMP};
    endfunction

    // Compare family: touches only the ordering flags
    function automatic logic is_cmp_op(input op_e op);
        return op inside {OP_SINGLE_CMP, OP_DOUBLE_CMP};
    endfunction

    // Zero test over the whole accumulator, shared by both flag paths
    function automatic logic is_zero(input logic [FULL_W-1:0] val);
        return (val == '0);
    endfunction

    // Replace the low half and keep the upper half as it is
    function automatic logic [FULL_W-1:0] merge_low(input logic [FULL_W-1:0] acc,
                                                    input logic [HALF_W-1:0] low);
        return {acc[FULL_W-1:HALF_W], low};
    endfunction

    // ======================================================================
    // Request handshake
    // Single-cycle unit, never stalls: ready is a constant, so a request
    // is taken on the very edge at which cmd_valid_i is seen high
    assign cmd_ready_o = 1'b1;
    assign take        = cmd_valid_i & cmd_ready_o;

    // ======================================================================
    // Comparator
    // Purely combinational; its outputs matter only while a compare is
    // presented, and both sides are zero extended at single width
    alcu_compare #(
        .FULL_W (FULL_W),
        .HALF_W (HALF_W)
    ) u_cmp (
        .acc_i     (acc_q),
        .operand_i (cmd_i.operand),
        .double_i  (is_double_op(cmd_i.op)),
        .lt_o      (cmp_lt),
        .eq_o      (cmp_eq),
        .gt_o      (cmp_gt)
    );

    // ======================================================================
    // Accumulator next value
    // Single forms patch only the low half, so an upper half seeded by a
    // double load survives a run of 16-bit logic instructions.
    // Unknown opcodes fall to the default and leave it untouched.
    always_comb begin
        acc_d = acc_q;
        if (take) begin
            unique case (cmd_i.op)
                OP_SINGLE_OR: begin
                    acc_d = merge_low(acc_q, acc_q[HALF_W-1:0]
                                      | cmd_i.operand[HALF_W-1:0]);
                end
                OP_DOUBLE_OR: begin
                    acc_d = acc_q | cmd_i.operand;
                end
                OP_SINGLE_XOR: begin
                    acc_d = merge_low(acc_q, acc_q[HALF_W-1:0]
                                      ^ cmd_i.operand[HALF_W-1:0]);
                end
                OP_DOUBLE_XOR: begin
                    acc_d = acc_q ^ cmd_i.operand;
                end
                OP_LOAD: begin
                    // Load path lets the sequencer seed the accumulator
                    acc_d = cmd_i.operand;
                end
                OP_SINGLE_CMP, OP_DOUBLE_CMP: begin
                    // Compares only read the accumulator
                    acc_d = acc_q;
                end
                default: begin
                    // Illegal opcode is ignored rather than trapped
                    acc_d = acc_q;
                end
            endcase
        end
    end

    // Accumulator register
    // Reset value comes from the shared constants, cut to this width
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= FULL_W'(`ALCU_ACC_RESET);
        end else begin
            acc_q <= acc_d;
        end
    end

    // ======================================================================
    // Status flags next value
    // Every flag keeps its value until an instruction of its own family
    // overwrites it; readers must sample between instructions
    always_comb begin
        flags_d = flags_q;
        if (take && is_logic_op(cmd_i.op)) begin
            // Taken from acc_d so flags land on the same edge as the result
            flags_d.zero_result_flag = is_zero(acc_d);
            if (is_double_op(cmd_i.op)) begin
                flags_d.negative_flag = acc_d[FULL_W-1];
            end else begin
                // Single width has no sign; flag marks a zero result
                flags_d.negative_flag = is_zero(acc_d);
            end
        end
        if (take && is_cmp_op(cmd_i.op)) begin
            // Comparator yields exactly one ordering flag
            flags_d.less_than_flag    = cmp_lt;
            flags_d.equal_flag        = cmp_eq;
            flags_d.greater_than_flag = cmp_gt;
        end
    end

    // Flag register
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ======================================================================
    // Completion strobe
    // Pulses for every taken request, illegal codes included, so the
    // sequencer never stalls on an opcode this unit does not decode
    always_comb begin
        done_d = take;
    end

    // Strobe register; high for exactly one cycle per request
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // ======================================================================
    // Outputs
    // All data outputs come straight from flip-flops; the only
    // combinational output is the constant ready
    assign acc_o   = acc_q;
    assign flags_o = flags_q;
    assign done_o  = done_q;

endmodule

// ==== test/alcu_chk.sv ====
// Port checker for the accumulator logic and compare unit
`timescale 1ns/1ps
module alcu_chk
    import alcu_pkg::*;
#(
    parameter int FULL_W = 32
) (
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic              cmd_valid_i,
    input wire cmd_s              cmd_i,
    input wire logic              cmd_ready_o,
    input wire logic              done_o,
    input wire logic [FULL_W-1:0] acc_o,
    input wire flags_s            flags_o
);
    // =====================================================================
    // Decode: one hit bit per opcode, logic ops sit in codes 0 to 3
    logic [7:0]  hit;
    logic        cmp_v;
    logic [31:0] v;
    logic [31:0] ka;
    logic [31:0] kb;
    assign hit   = cmd_valid_i ? 8'h01 << cmd_i.op : 8'h00;
    assign cmp_v = hit[OP_SINGLE_CMP] | hit[OP_DOUBLE_CMP];
    assign v     = cmd_i.operand;
    // Single compare must ignore the upper halves
    assign ka = (cmd_i.op == OP_DOUBLE_CMP) ? acc_o : {16'h0000, acc_o[15:0]};
    assign kb = (cmd_i.op == OP_DOUBLE_CMP) ? v : {16'h0000, v[15:0]};
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // =====================================================================
    // Properties
    a_or_dbl: assert property (hit[OP_DOUBLE_OR] |=> acc_o == $past(acc_o | v))
        else $error("double or result wrong");
    a_xor_dbl: assert property (hit[OP_DOUBLE_XOR] |=> acc_o == $past(acc_o ^ v))
        else $error("double xor result wrong");
    a_or_sgl: assert property (hit[OP_SINGLE_OR] |=>
        acc_o == $past({acc_o[31:16], acc_o[15:0] | v[15:0]})) else $error("single or wrong");
    a_xor_sgl: assert property (hit[OP_SINGLE_XOR] |=>
        acc_o == $past({acc_o[31:16], acc_o[15:0] ^ v[15:0]})) else $error("single xor wrong");
    a_cmp_keep: assert property (cmp_v |=> $stable(acc_o))
        else $error("compare altered accumulator");
    a_cmp_order: assert property (cmp_v |=>
        flags_o[2:0] == $past({ka < kb, ka == kb, ka > kb})) else $error("order flags wrong");
    a_zero_flag: assert property (|hit[3:0] |=> flags_o.zero_result_flag == (acc_o == 0))
        else $error("zero flag wrong");
    a_neg_flag: assert property (|hit[3:0] |=> flags_o.negative_flag ==
        ($past(hit[1] | hit[3]) ? acc_o[31] : acc_o == 0)) else $error("negative flag wrong");
    a_flags_hold: assert property (!cmd_valid_i |=> $stable(flags_o))
        else $error("flags changed while idle");
    a_done_pulse: assert property (done_o == $past(cmd_valid_i))
        else $error("done strobe wrong");
    cover property (cmp_v);
    cover property (hit[OP_SINGLE_OR]);
    cover property (cmd_valid_i && $past(cmd_valid_i));
endmodule

bind accum_logic_compare_unit alcu_chk #(.FULL_W(FULL_W)) i_chk (.clk_sys_i, .rst_n_i,
    .cmd_valid_i, .cmd_i, .cmd_ready_o, .done_o, .acc_o, .flags_o);

// ==== test/alcu_seq_model.sv ====
// Sequencer and data memory model feeding the unit
`timescale 1ns/1ps
module alcu_seq_model
    import alcu_pkg::*;
(
    input  wire logic clk_sys_i,
    output logic      cmd_valid_o,
    output cmd_s      cmd_o
);
    // =====================================================================
    // Data memory; a pair puts its first word high
    logic [15:0] mem [0:3] = '{16'h8421, 16'h1234, 16'h00f0, 16'h0f0f};
    function automatic logic [31:0] pair(input int a);
        return {mem[a], mem[a+1]};
    endfunction
    initial cmd_valid_o = 1'b0;
    initial cmd_o = '0;
    // Held to the taking edge; released data is inverted so stale values never match
    task automatic issue(input op_e op, input logic [31:0] v, input bit last);
        cmd_valid_o <= 1'b1;
        cmd_o       <= '{op, v};
        @(posedge clk_sys_i);
        if (last) begin
            cmd_valid_o   <= 1'b0;
            cmd_o.operand <= ~v;
        end
    endtask
endmodule

// ==== test/tb_accum_logic_compare_unit.sv ====
// Self-checking bench for the accumulator logic and compare unit
`timescale 1ns/1ps
module tb_accum_logic_compare_unit;
    import alcu_pkg::*;
    logic        clk_sys_i, rst_n_i, cmd_valid_i, cmd_ready_o, done_o;
    cmd_s        cmd_i;
    logic [31:0] acc_o, acc;
    flags_s      flags_o, fl;
    int          n_errors, checks_done;
    accum_logic_compare_unit i_dut (.clk_sys_i, .rst_n_i, .cmd_valid_i, .cmd_i,
        .cmd_ready_o, .done_o, .acc_o, .flags_o);
    alcu_seq_model i_seq (.clk_sys_i, .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    // 50 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reference update, then issue; codes 0 to 3 are logic ops, odd ones double
    task automatic run(input op_e op, input logic [31:0] v, input bit last = 1);
        logic [31:0] r, a, b;
        r = acc;
        a = op == OP_DOUBLE_CMP ? acc : {16'h0000, acc[15:0]};
        b = op == OP_DOUBLE_CMP ? v : {16'h0000, v[15:0]};
        case (op)
            OP_SINGLE_OR:  r[15:0] = acc[15:0] | v[15:0];
            OP_SINGLE_XOR: r[15:0] = acc[15:0] ^ v[15:0];
            OP_DOUBLE_OR:  r = acc | v;
            OP_DOUBLE_XOR: r = acc ^ v;
            OP_LOAD:       r = v;
            OP_SINGLE_CMP, OP_DOUBLE_CMP: fl[2:0] = {a < b, a == b, a > b};
            default: ;
        endcase
        if (op < OP_SINGLE_CMP) fl[4:3] = {r == 0, op[0] ? r[31] : r == 0};
        acc = r;
        i_seq.issue(op, v, last);
        if (last) begin
            #1;
            chk(done_o, 1);
            chk(cmd_ready_o, 1);
            chk(acc_o, acc);
            chk(flags_o, fl);
            $display("test %s done", op.name());
            @(posedge clk_sys_i);
        end
    endtask
    // Hang guard
    initial begin
        #100us;
        n_errors++;
        end_sim();
    end
    initial begin
        rst_n_i = 1'b0;
        acc = '0;
        fl = '0;
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        run(OP_LOAD, 32'hffff_0000);
        run(OP_SINGLE_OR, {16'h0000, i_seq.mem[1]});
        run(OP_SINGLE_XOR, {16'h0000, i_seq.mem[1]});
        run(OP_LOAD, 32'h0000_0000);
        run(OP_SINGLE_OR, 32'h0000_0000);
        run(OP_DOUBLE_OR, i_seq.pair(0));
        run(OP_DOUBLE_XOR, i_seq.pair(0));
        run(OP_DOUBLE_OR, 32'h8000_0001);
        run(OP_DOUBLE_CMP, 32'h0000_0002);
        run(OP_DOUBLE_CMP, 32'h8000_0001);
        run(OP_DOUBLE_CMP, 32'hffff_ffff);
        run(OP_SINGLE_CMP, 32'hffff_0001);
        run(OP_SINGLE_CMP, i_seq.pair(2));
        run(op_e'(3'h7), 32'h0000_0000);
        run(OP_DOUBLE_XOR, 32'h1234_5678, 0);
        run(OP_DOUBLE_XOR, 32'h1234_5678);
        rst_n_i <= 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk(acc_o, 0);
        chk(flags_o, 0);
        chk(done_o, 0);
        $display("test reset done");
        acc = '0;
        fl = '0;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        run(OP_DOUBLE_OR, i_seq.pair(2));
        end_sim();
    end
endmodule
